// file: design/ilasc_cfg.svh
// Offsets, field positions, reset values and codes of the lane 0 link configuration capture block
`ifndef ILASC_CFG_SVH
`define ILASC_CFG_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define ILASC_ADDR_W          16
`define ILASC_IDX_W           14
`define ILASC_DATA_W          32

// ****************************************************************
// Register indexes; byte address is four times the index
// ****************************************************************
`define ILASC_IDX_LANE_IDENT  14'h0402
`define ILASC_IDX_SCR_LANES   14'h0403
`define ILASC_IDX_OCT_FRAME   14'h0404
`define ILASC_IDX_FRM_MFRAME  14'h0405
`define ILASC_IDX_CONV_CNT    14'h0406
`define ILASC_IDX_CAP_STATUS  14'h040F

// ****************************************************************
// Position of each field octet within the alignment sequence
// ****************************************************************
`define ILASC_OCT_IDX_W       4
`define ILASC_OCT_LANE_IDENT  4'h2
`define ILASC_OCT_SCR_LANES   4'h3
`define ILASC_OCT_OCT_FRAME   4'h4
`define ILASC_OCT_FRM_MFRAME  4'h5
`define ILASC_OCT_CONV_CNT    4'h6

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define ILASC_NUM_FIELDS      5
`define ILASC_SCR_BIT         7
`define ILASC_FIELD5_W        5
`define ILASC_RST5            5'h00
`define ILASC_RST8            8'h00
`define ILASC_RST_SEEN        5'h00

// ****************************************************************
// Bus response codes
// ****************************************************************
`define ILASC_RESP_OKAY       2'h0
`define ILASC_RESP_SLVERR     2'h2

`endif

// file: design/ilasc_pkg.sv
// Types shared by the lane 0 link configuration capture block
`default_nettype none

`include "ilasc_cfg.svh"

package ilasc_pkg;

  // Captured configuration of lane 0
  typedef struct packed {
    logic [4:0] lane_ident;
    logic       scramble_flag;
    logic [4:0] lane_count;
    logic [7:0] octets_per_frame;
    logic [4:0] frames_per_multiframe;
    logic [7:0] converter_count;
  } ilasc_fields_t;

  // Capture side state
  typedef struct packed {
    ilasc_fields_t                  fields;
    logic [`ILASC_NUM_FIELDS-1:0]   seen;
  } ilasc_cap_state_t;

  // Register bus slave state
  typedef struct packed {
    logic                           awready;
    logic                           wready;
    logic                           aw_got;
    logic                           w_got;
    logic [`ILASC_IDX_W-1:0]        widx;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           arready;
    logic                           rvalid;
    logic [`ILASC_DATA_W-1:0]       rdata;
    logic [1:0]                     rresp;
  } ilasc_bus_state_t;

endpackage : ilasc_pkg

`default_nettype wire

// file: design/ilasc_cap_if.sv
// Carrier of captured fields from the capture stage to the register bank
`default_nettype none

`include "ilasc_cfg.svh"

interface ilasc_cap_if;
  ilasc_pkg::ilasc_fields_t       fields;
  logic [`ILASC_NUM_FIELDS-1:0]   seen;

  modport producer (output fields, output seen);
  modport consumer (input fields, input seen);
endinterface : ilasc_cap_if

`default_nettype wire

// file: design/ilasc_capture.sv
// Capture of lane 0 alignment sequence configuration octets
`default_nettype none

`include "ilasc_cfg.svh"

module ilasc_capture (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // Octet stream of lane 0
  input  wire logic                          octet_valid,
  input  wire logic [`ILASC_OCT_IDX_W-1:0]   octet_index,
  input  wire logic [7:0]                    octet_data,
  input  wire logic                          ilas_start,
  // Captured fields
  ilasc_cap_if.producer                      cap
);

  localparam logic [`ILASC_OCT_IDX_W-1:0] OCT_POS [`ILASC_NUM_FIELDS] = '{
    `ILASC_OCT_LANE_IDENT, `ILASC_OCT_SCR_LANES, `ILASC_OCT_OCT_FRAME,
    `ILASC_OCT_FRM_MFRAME, `ILASC_OCT_CONV_CNT};

  ilasc_pkg::ilasc_cap_state_t st_ff;
  ilasc_pkg::ilasc_cap_state_t nxt_st;
  logic [`ILASC_NUM_FIELDS-1:0] hit;

  // ****************************************************************
  // Octet position match per field
  // ****************************************************************
  for (genvar i = 0; i < `ILASC_NUM_FIELDS; i++) begin : g_hit
    assign hit[i] = octet_valid && (octet_index == OCT_POS[i]); // R10
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    if (ilas_start) begin
      nxt_st.seen = `ILASC_RST_SEEN;
    end
    // A hit in the clearing cycle still marks its field as seen
    nxt_st.seen = nxt_st.seen | hit;
    if (hit[0]) begin
      nxt_st.fields.lane_ident = octet_data[4:0]; // R2
    end
    if (hit[1]) begin
      nxt_st.fields.scramble_flag = octet_data[`ILASC_SCR_BIT]; // R3
      nxt_st.fields.lane_count    = octet_data[4:0]; // R4
    end
    if (hit[2]) begin
      nxt_st.fields.octets_per_frame = octet_data; // R5
    end
    if (hit[3]) begin
      nxt_st.fields.frames_per_multiframe = octet_data[4:0]; // R6
    end
    if (hit[4]) begin
      nxt_st.fields.converter_count = octet_data; // R9
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st; // R1
    end
  end

  assign cap.fields = st_ff.fields;
  assign cap.seen   = st_ff.seen;

endmodule : ilasc_capture

`default_nettype wire

// file: design/ilasc_regbank.sv
// Register bank presenting the captured lane 0 link configuration over AXI4-Lite
// Function
// (R1) Store lane 0 configuration, expose read-only
// (R2) Lane identifier in bits 4:0, reset zero
// (R3) Scrambling status in bit 7
// (R4) Lane count as count minus one
// (R5) Octets per frame at 0x404, minus one
// (R6) Frames per multiframe bits 4:0 at 0x405
// (R7) Transmitter uses 32 frames, field reads 31
// (R8) Reserved bits read as zero
// (R9) Converter count at 0x406, minus one
// (R10) Update on matching octet; ignore writes
`default_nettype none

`include "ilasc_cfg.svh"

module ilasc_regbank (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // Octet stream of lane 0 from the lane receiver
  input  wire logic                          octet_valid,
  input  wire logic [`ILASC_OCT_IDX_W-1:0]   octet_index,
  input  wire logic [7:0]                    octet_data,
  input  wire logic                          ilas_start,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [`ILASC_ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [`ILASC_DATA_W-1:0]      s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [`ILASC_ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  // AXI4-Lite read data
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [`ILASC_DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                         s_axi_rresp
);

  // ****************************************************************
  // Capture stage
  // ****************************************************************
  ilasc_cap_if cap_bus ();

  ilasc_capture u_capture (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .octet_valid (octet_valid),
    .octet_index (octet_index),
    .octet_data  (octet_data),
    .ilas_start  (ilas_start),
    .cap         (cap_bus.producer)
  );

  // ****************************************************************
  // Address decode and read data
  // ****************************************************************
  // Returns {mapped, data}; unused upper bits always zero
  function automatic logic [`ILASC_DATA_W:0] ilasc_read_word(
    input logic [`ILASC_IDX_W-1:0]      idx,
    input ilasc_pkg::ilasc_fields_t     f,
    input logic [`ILASC_NUM_FIELDS-1:0] seen
  );
    logic [`ILASC_DATA_W:0] res;
    res = '0;
    case (idx)
      `ILASC_IDX_LANE_IDENT: begin
        res[`ILASC_DATA_W] = 1'b1;
        res[4:0]           = f.lane_ident; // R2
      end
      `ILASC_IDX_SCR_LANES: begin
        res[`ILASC_DATA_W]  = 1'b1;
        res[`ILASC_SCR_BIT] = f.scramble_flag; // R3
        res[6:5]            = 2'h0; // R8
        res[4:0]            = f.lane_count; // R4
      end
      `ILASC_IDX_OCT_FRAME: begin
        res[`ILASC_DATA_W] = 1'b1;
        res[7:0]           = f.octets_per_frame; // R5
      end
      `ILASC_IDX_FRM_MFRAME: begin
        res[`ILASC_DATA_W] = 1'b1;
        res[7:5]           = 3'h0; // R8
        res[4:0]           = f.frames_per_multiframe; // R6 R7
      end
      `ILASC_IDX_CONV_CNT: begin
        res[`ILASC_DATA_W] = 1'b1;
        res[7:0]           = f.converter_count; // R9
      end
      `ILASC_IDX_CAP_STATUS: begin
        res[`ILASC_DATA_W]            = 1'b1;
        res[`ILASC_NUM_FIELDS-1:0]    = seen;
      end
      default: begin
        res = '0;
      end
    endcase
    return res;
  endfunction : ilasc_read_word

  function automatic logic ilasc_mapped(input logic [`ILASC_IDX_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      `ILASC_IDX_LANE_IDENT,
      `ILASC_IDX_SCR_LANES,
      `ILASC_IDX_OCT_FRAME,
      `ILASC_IDX_FRM_MFRAME,
      `ILASC_IDX_CONV_CNT,
      `ILASC_IDX_CAP_STATUS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : ilasc_mapped

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  ilasc_pkg::ilasc_bus_state_t st_ff;
  ilasc_pkg::ilasc_bus_state_t nxt_st;
  logic [`ILASC_DATA_W:0]      rd_word;

  assign rd_word = ilasc_read_word(s_axi_araddr[`ILASC_ADDR_W-1:2], cap_bus.fields, cap_bus.seen);

  always_comb begin
    nxt_st = st_ff;

    // Write address and data accepted in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.widx   = s_axi_awaddr[`ILASC_ADDR_W-1:2];
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Both halves held: answer, data discarded
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = ilasc_mapped(st_ff.widx) ? `ILASC_RESP_OKAY : `ILASC_RESP_SLVERR; // R10
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

    // Read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_word[`ILASC_DATA_W-1:0]; // R1
      nxt_st.rresp  = rd_word[`ILASC_DATA_W] ? `ILASC_RESP_OKAY : `ILASC_RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

endmodule : ilasc_regbank

`default_nettype wire

// file: test/ilasc_regbank_sva.sv
// Bus timing and read-word shape checks of the lane 0 configuration capture bank
`default_nettype none
`include "ilasc_cfg.svh"
module ilasc_regbank_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] ridx_ff;
  logic [13:0] widx_ff;
  // Index of the access under way
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ridx_ff <= 14'h0000;
      widx_ff <= 14'h0000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) ridx_ff <= s_axi_araddr[15:2];
      if (s_axi_awvalid && s_axi_awready) widx_ff <= s_axi_awaddr[15:2];
    end
  end
  function automatic logic mapped(input logic [13:0] i);
    return (i >= `ILASC_IDX_LANE_IDENT && i <= `ILASC_IDX_CONV_CNT) || i == `ILASC_IDX_CAP_STATUS;
  endfunction : mapped
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not on next cycle");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read word dropped before taken");
  property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read channel not freed");
  property p_lid; s_axi_rvalid && ridx_ff == `ILASC_IDX_LANE_IDENT |-> s_axi_rdata[31:5] == 27'h0; endproperty
  a_lid: assert property (p_lid) else $error("lane ident upper bits set");
  property p_scr;
    s_axi_rvalid && ridx_ff == `ILASC_IDX_SCR_LANES |-> !s_axi_rdata[31:8] && !s_axi_rdata[6:5];
  endproperty
  a_scr: assert property (p_scr) else $error("scramble word reserved bits set");
  property p_kfr; s_axi_rvalid && ridx_ff == `ILASC_IDX_FRM_MFRAME |-> s_axi_rdata[31:5] == 27'h0; endproperty
  a_kfr: assert property (p_kfr) else $error("frame count reserved bits set");
  property p_unm;
    s_axi_rvalid && !mapped(ridx_ff) |-> s_axi_rdata == 32'h0 && s_axi_rresp == `ILASC_RESP_SLVERR;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answered wrongly");
  property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer not two cycles on");
  property p_wr_resp;
    s_axi_bvalid |-> s_axi_bresp == (mapped(widx_ff) ? `ILASC_RESP_OKAY : `ILASC_RESP_SLVERR);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response code wrong");
  c_rd: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `ILASC_RESP_OKAY);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == `ILASC_RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : ilasc_regbank_sva
bind ilasc_regbank ilasc_regbank_sva ilasc_regbank_sva_i (.mclk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// file: test/ilasc_tx_model.sv
// Lane 0 transmitter model sending the alignment-sequence configuration octets
`default_nettype none
module ilasc_tx_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Octet stream
  output wire logic       octet_valid,
  output wire logic [3:0] octet_index,
  output wire logic [7:0] octet_data,
  output var  logic       ilas_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        vld_q = 1'b0;
  logic [11:0] frm_q = 12'h000;
  logic [11:0] idle_q = 12'h5A3;
  initial ilas_start = 1'b0;
  // Outside a frame the lines keep changing
  always @(posedge mclk) idle_q <= ~idle_q;
  assign octet_valid = vld_q;
  assign {octet_index, octet_data} = vld_q ? frm_q : idle_q;
  task automatic send(input logic [4:0] lid, input logic scr, input logic [4:0] lanes,
                      input logic [7:0] f, input logic [7:0] m, input logic full);
    @(posedge mclk);
    ilas_start <= 1'b1;
    @(posedge mclk);
    ilas_start <= 1'b0;
    for (int i = 0; i < 14 && full; i++) begin
      vld_q <= 1'b1;
      frm_q <= {4'(i), i == 2 ? {3'h0, lid} : i == 3 ? {scr, 2'h0, lanes} : i == 4 ? f :
                i == 5 ? 8'h1F : i == 6 ? m : ~f};
      @(posedge mclk);
    end
    vld_q <= 1'b0;
  endtask : send
endmodule : ilasc_tx_model
`default_nettype wire

// file: test/ilasc_regbank_test.sv
// Self-checking bench of the lane 0 configuration capture bank
`default_nettype none
`include "ilasc_cfg.svh"
`define CHK(a, e, m) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("wrong value %0t %s", $time, m); \
  end \
end
module ilasc_regbank_test;
  timeunit 1ns;
  timeprecision 1ps;
  wire logic   octet_valid, ilas_start;
  wire logic [3:0] octet_index;
  wire logic [7:0] octet_data;
  logic        mclk = 1'b0, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h0DB24F7D;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  lid, cd;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          fails = 0, tests_run = 0;
  logic [13:0] idxs [6] = '{`ILASC_IDX_LANE_IDENT, `ILASC_IDX_SCR_LANES, `ILASC_IDX_OCT_FRAME,
                            `ILASC_IDX_FRM_MFRAME, `ILASC_IDX_CONV_CNT, `ILASC_IDX_CAP_STATUS};
  always #2 mclk = ~mclk;
  ilasc_tx_model ilasc_tx_model_i (.mclk, .arst_n, .octet_valid, .octet_index, .octet_data, .ilas_start);
  ilasc_regbank ilasc_regbank_i (.mclk, .arst_n, .octet_valid, .octet_index, .octet_data, .ilas_start,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic rd(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back({er, ed});
    rnd = lfsr(rnd);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arprot  <= rnd[4:2];
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    // Random stall of the read answer
    if (rnd[5]) @(posedge mclk);
    s_axi_rready  <= 1'b1;
    do @(negedge mclk); while (!s_axi_rvalid);
    @(posedge mclk);
    s_axi_rready  <= 1'b0;
  endtask : rd
  task automatic wr(input logic [13:0] idx, input logic [1:0] er);
    bq.push_back(er);
    rnd = lfsr(rnd);
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= rnd;
    s_axi_wstrb   <= rnd[3:0];
    s_axi_awprot  <= rnd[6:4];
    do @(negedge mclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge mclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b1;
    do @(negedge mclk); while (!s_axi_bvalid);
    @(posedge mclk);
    s_axi_bready  <= 1'b0;
  endtask : wr
  task automatic rd_all(input logic [31:0] v [6]);
    for (int i = 0; i < 6; i++) rd(idxs[i], v[i], `ILASC_RESP_OKAY);
  endtask : rd_all
  task automatic stop_test;
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // Oldest note against each answer
  always @(negedge mclk) begin
    if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read word")
    if (s_axi_bvalid && s_axi_bready) `CHK(s_axi_bresp, bq.pop_front(), "write response")
  end
  initial begin
    #20000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rd_all('{6{32'h0}});
    rd(14'h0400, 32'h0, `ILASC_RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      lid = rnd[4:0];
      cd = 5'((1 << i) - 1);
      ilasc_tx_model_i.send(lid, i[0], cd, 8'(cd), 8'(i[0]), 1'b1);
      rd_all('{{27'h0, lid}, {24'h0, i[0], 2'h0, cd}, {27'h0, cd}, 32'h1F, {31'h0, i[0]}, 32'h1F});
    end
    for (int i = 0; i < 6; i++) wr(idxs[i], `ILASC_RESP_OKAY);
    wr(14'h0401, `ILASC_RESP_SLVERR);
    ilasc_tx_model_i.send(5'h00, 1'b0, 5'h00, 8'h00, 8'h00, 1'b0);
    rd_all('{{27'h0, lid}, 32'h3, 32'h3, 32'h1F, 32'h0, 32'h0});
    stop_test();
  end
endmodule : ilasc_regbank_test
`default_nettype wire
